// ### ces_pkg.sv
package ces_pkg;
	// Register indices; the byte address on the bus is four times the index
	localparam logic [11:0] IDX_EDGE_TYPE_PARAM    = 12'h0517;
	localparam logic [11:0] IDX_EDGE_STYLE_SELECT  = 12'h0518;
	localparam logic [11:0] IDX_EDGE_LENGTH_CONFIG = 12'h0519;
	localparam logic [11:0] IDX_SHAPER_CTRL        = 12'h051A;
	localparam logic [11:0] IDX_SHAPER_STATUS      = 12'h051B;
	localparam int          ADDR_W                 = 16;
	localparam logic [15:0] ADDR_EDGE_TYPE_PARAM    = {2'b00, IDX_EDGE_TYPE_PARAM, 2'b00};
	localparam logic [15:0] ADDR_EDGE_STYLE_SELECT  = {2'b00, IDX_EDGE_STYLE_SELECT, 2'b00};
	localparam logic [15:0] ADDR_EDGE_LENGTH_CONFIG = {2'b00, IDX_EDGE_LENGTH_CONFIG, 2'b00};
	localparam logic [15:0] ADDR_SHAPER_CTRL        = {2'b00, IDX_SHAPER_CTRL, 2'b00};
	localparam logic [15:0] ADDR_SHAPER_STATUS      = {2'b00, IDX_SHAPER_STATUS, 2'b00};

	// Field positions
	localparam int FALL_TYPE_HI  = 7;
	localparam int FALL_TYPE_LO  = 4;
	localparam int RISE_TYPE_HI  = 3;
	localparam int RISE_TYPE_LO  = 0;
	localparam int FALL_STYLE_HI = 6;
	localparam int FALL_STYLE_LO = 4;
	localparam int RISE_STYLE_HI = 2;
	localparam int RISE_STYLE_LO = 0;
	localparam int LEN_DOUBLE    = 7;
	localparam int LEN_STATES_HI = 4;
	localparam int LEN_STATES_LO = 0;
	localparam int CTRL_FALL     = 0;
	localparam int CTRL_RISE     = 1;

	// Reset values
	localparam logic [7:0] RST_EDGE_TYPE   = 8'h11;
	localparam logic [7:0] RST_EDGE_STYLE  = 8'h00;
	localparam logic [7:0] RST_EDGE_LENGTH = 8'h08;
	localparam logic [7:0] AMP_LOW         = 8'h00;
	localparam logic [7:0] AMP_HIGH        = 8'hFF;

	// Edge type codes
	localparam logic [3:0] ET_LIN1     = 4'h1;
	localparam logic [3:0] ET_LIN2     = 4'h2;
	localparam logic [3:0] ET_LIN3     = 4'h3;
	localparam logic [3:0] ET_LUT_NONE = 4'h4;
	localparam logic [3:0] ET_LUT_CORR = 4'h5;
	localparam logic [3:0] ET_LUT_RAW  = 4'h6;

	typedef enum logic [1:0] {CES_IDLE, CES_RUN} ces_state_t;
endpackage : ces_pkg

// ### ces_shaper.sv
// The APB interface to the registers is this design's own decision.
module ces_shaper #(
	parameter int CARRIER_DIV = 4
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [15:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Supply compensation input from the PA supply monitor
	input  wire logic [7:0]  pa_supply_gain,
	// Envelope output
	output logic      [7:0]  env_amp,
	output logic             env_busy,
	output logic             env_done
);
	// The divider counter is eight bits wide, so larger ratios cannot be served
	if (CARRIER_DIV < 1 || CARRIER_DIV > 255) begin : g_bad_div
		$error("CARRIER_DIV out of range");
	end

	logic [7:0] edge_type_param_ff, nxt_edge_type_param;
	logic [7:0] edge_style_select_ff, nxt_edge_style_select;
	logic [7:0] edge_length_config_ff, nxt_edge_length_config;
	logic [7:0] div_ff, nxt_div;
	logic       carrier_tick;
	logic       apb_wr, apb_rd, hit;
	logic [31:0] nxt_prdata;
	logic [31:0] prdata_ff;
	logic [7:0] pa_sync1_ff, pa_sync2_ff;

	ces_pkg::ces_state_t state_ff, nxt_state;
	logic       falling_ff, nxt_falling;
	logic [4:0] step_ff, nxt_step;
	logic [4:0] nstates_ff, nxt_nstates;
	logic       half_ff, nxt_half;
	logic       dbl_ff, nxt_dbl;
	logic [3:0] type_ff, nxt_type;
	logic [2:0] style_ff, nxt_style;
	logic [7:0] amp_ff, nxt_amp;
	logic       done_ff, nxt_done;

	// Transfer decode; single-cycle access phase
	assign apb_wr  = psel && penable && pwrite;
	assign apb_rd  = psel && !penable && !pwrite;
	assign pready  = 1'b1;
	assign hit     = (paddr == ces_pkg::ADDR_EDGE_TYPE_PARAM) ||
	                 (paddr == ces_pkg::ADDR_EDGE_STYLE_SELECT) ||
	                 (paddr == ces_pkg::ADDR_EDGE_LENGTH_CONFIG) ||
	                 (paddr == ces_pkg::ADDR_SHAPER_CTRL) ||
	                 (paddr == ces_pkg::ADDR_SHAPER_STATUS);
	assign pslverr = psel && penable && !hit;
	assign prdata  = prdata_ff;

	// Register writes and read mux
	always_comb begin
		nxt_edge_type_param    = edge_type_param_ff;
		nxt_edge_style_select  = edge_style_select_ff;
		nxt_edge_length_config = edge_length_config_ff;
		nxt_prdata             = prdata_ff;
		if (apb_wr) begin
			case (paddr)
				ces_pkg::ADDR_EDGE_TYPE_PARAM:    nxt_edge_type_param = pwdata[7:0];
				ces_pkg::ADDR_EDGE_STYLE_SELECT:  nxt_edge_style_select = pwdata[7:0];
				ces_pkg::ADDR_EDGE_LENGTH_CONFIG: nxt_edge_length_config = pwdata[7:0];
				default: ;
			endcase
		end
		// Read data captured in setup so it stands through the access cycle
		if (apb_rd) begin
			case (paddr)
				ces_pkg::ADDR_EDGE_TYPE_PARAM:    nxt_prdata = {24'h00_0000, edge_type_param_ff};
				ces_pkg::ADDR_EDGE_STYLE_SELECT:  nxt_prdata = {24'h00_0000, edge_style_select_ff};
				ces_pkg::ADDR_EDGE_LENGTH_CONFIG: nxt_prdata = {24'h00_0000, edge_length_config_ff};
				ces_pkg::ADDR_SHAPER_STATUS:      nxt_prdata = {16'h0000, step_ff, done_ff,
				                                                 state_ff == ces_pkg::CES_RUN,
				                                                 falling_ff, amp_ff};
				default:                          nxt_prdata = 32'h0000_0000;
			endcase
		end
	end

	// Carrier-cycle enable from the system clock
	always_comb begin
		nxt_div      = (div_ff == 8'(CARRIER_DIV - 1)) ? 8'h00 : div_ff + 8'h01;
		carrier_tick = (div_ff == 8'(CARRIER_DIV - 1));
	end

	// Sequencer: one state per carrier cycle, or per two when doubled
	always_comb begin
		logic [4:0] idx;
		logic [7:0] lin;
		logic [8:0] prod;
		logic [7:0] target, start;
		idx = 5'h00;
		lin = 8'h00;
		prod = 9'h000;
		nxt_state   = state_ff;
		nxt_falling = falling_ff;
		nxt_step    = step_ff;
		nxt_nstates = nstates_ff;
		nxt_half    = half_ff;
		nxt_dbl     = dbl_ff;
		nxt_type    = type_ff;
		nxt_style   = style_ff;
		nxt_amp     = amp_ff;
		nxt_done    = 1'b0;
		target = falling_ff ? ces_pkg::AMP_LOW : ces_pkg::AMP_HIGH;
		start  = falling_ff ? ces_pkg::AMP_HIGH : ces_pkg::AMP_LOW;
		case (state_ff)
			ces_pkg::CES_IDLE: begin
				if (apb_wr && paddr == ces_pkg::ADDR_SHAPER_CTRL &&
				    (pwdata[ces_pkg::CTRL_FALL] || pwdata[ces_pkg::CTRL_RISE])) begin
					nxt_falling = pwdata[ces_pkg::CTRL_FALL];
					nxt_dbl     = edge_length_config_ff[ces_pkg::LEN_DOUBLE];
					nxt_nstates = edge_length_config_ff[ces_pkg::LEN_STATES_HI:ces_pkg::LEN_STATES_LO];
					nxt_type    = pwdata[ces_pkg::CTRL_FALL] ?
					              edge_type_param_ff[ces_pkg::FALL_TYPE_HI:ces_pkg::FALL_TYPE_LO] :
					              edge_type_param_ff[ces_pkg::RISE_TYPE_HI:ces_pkg::RISE_TYPE_LO];
					nxt_style   = pwdata[ces_pkg::CTRL_FALL] ?
					              edge_style_select_ff[ces_pkg::FALL_STYLE_HI:ces_pkg::FALL_STYLE_LO] :
					              edge_style_select_ff[ces_pkg::RISE_STYLE_HI:ces_pkg::RISE_STYLE_LO];
					nxt_step    = 5'h00;
					nxt_half    = 1'b0;
					nxt_state   = ces_pkg::CES_RUN;
				end
			end
			ces_pkg::CES_RUN: begin
				if (nstates_ff == 5'h00) begin
					nxt_amp   = target;
					nxt_done  = 1'b1;
					nxt_state = ces_pkg::CES_IDLE;
				end else if (carrier_tick) begin
					if (dbl_ff && !half_ff) begin
						nxt_half = 1'b1;
					end else begin
						nxt_half = 1'b0;
						idx      = step_ff + 5'h01;
						nxt_step = idx;
						// Linear fraction of the swing reached at this state
						lin = 8'((16'(idx) * 16'h00FF) / 16'(nstates_ff));
						case (type_ff)
							// Computed shaping; style sets segment weighting
							ces_pkg::ET_LIN1, ces_pkg::ET_LIN2, ces_pkg::ET_LIN3: begin
								prod = 9'(lin) + 9'(8'(lin >> (3'h7 - style_ff)) & 8'(type_ff - 4'h1));
								lin  = prod[8] ? 8'hFF : prod[7:0];
							end
							// Table shaping; style picks one of four curves
							ces_pkg::ET_LUT_NONE, ces_pkg::ET_LUT_CORR, ces_pkg::ET_LUT_RAW: begin
								case (style_ff[1:0])
									2'h0:    lin = lin;
									2'h1:    lin = 8'((16'(lin) * 16'(lin)) >> 8);
									2'h2:    lin = 8'hFF - 8'((16'(8'hFF - lin) * 16'(8'hFF - lin)) >> 8);
									default: lin = (lin < 8'h80) ? 8'(lin >> 1) : 8'(lin - 8'h40) | 8'h40;
								endcase
								if (type_ff != ces_pkg::ET_LUT_NONE) begin
									lin = 8'((16'(lin) * 16'(pa_sync2_ff)) >> 8);
									if (type_ff == ces_pkg::ET_LUT_CORR)
										lin = 8'(lin | (lin >> 4));
								end
							end
							default: ;
						endcase
						nxt_amp = falling_ff ? 8'(start - lin) : 8'(start + lin);
						if (idx == nstates_ff) begin
							nxt_amp   = target;
							nxt_done  = 1'b1;
							nxt_state = ces_pkg::CES_IDLE;
						end
					end
				end
			end
			default: nxt_state = ces_pkg::CES_IDLE;
		endcase
	end

	assign env_amp  = amp_ff;
	assign env_busy = (state_ff == ces_pkg::CES_RUN);
	assign env_done = done_ff;

	// Registers; supply level is from another domain so it is double-flopped
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			edge_type_param_ff    <= ces_pkg::RST_EDGE_TYPE;
			edge_style_select_ff  <= ces_pkg::RST_EDGE_STYLE;
			edge_length_config_ff <= ces_pkg::RST_EDGE_LENGTH;
			prdata_ff  <= 32'h0000_0000;
			div_ff     <= 8'h00;
			pa_sync1_ff <= 8'h00;
			pa_sync2_ff <= 8'h00;
			state_ff   <= ces_pkg::CES_IDLE;
			falling_ff <= 1'b0;
			step_ff    <= 5'h00;
			nstates_ff <= 5'h00;
			half_ff    <= 1'b0;
			dbl_ff     <= 1'b0;
			type_ff    <= 4'h0;
			style_ff   <= 3'h0;
			amp_ff     <= ces_pkg::AMP_HIGH;
			done_ff    <= 1'b0;
		end else begin
			edge_type_param_ff    <= nxt_edge_type_param;
			edge_style_select_ff  <= nxt_edge_style_select;
			edge_length_config_ff <= nxt_edge_length_config;
			prdata_ff  <= nxt_prdata;
			div_ff     <= nxt_div;
			pa_sync1_ff <= pa_supply_gain;
			pa_sync2_ff <= pa_sync1_ff;
			state_ff   <= nxt_state;
			falling_ff <= nxt_falling;
			step_ff    <= nxt_step;
			nstates_ff <= nxt_nstates;
			half_ff    <= nxt_half;
			dbl_ff     <= nxt_dbl;
			type_ff    <= nxt_type;
			style_ff   <= nxt_style;
			amp_ff     <= nxt_amp;
			done_ff    <= nxt_done;
		end
	end
endmodule : ces_shaper

// ### ces_shaper_monitor.sv
module ces_shaper_monitor #(
	parameter int CARRIER_DIV = 4
) (
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst_n,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Supply gain and envelope
	input wire logic [7:0]  pa_supply_gain,
	input wire logic [7:0]  env_amp,
	input wire logic        env_busy,
	input wire logic        env_done
);
	logic        acc;
	logic        mapped;
	logic        start;
	logic        fall_ff;
	logic        nxt_fall;
	logic [15:0] cnt_ff;
	logic [15:0] nxt_cnt;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Decode of accesses and of edge starts
	assign acc = psel && penable;
	assign mapped = paddr inside {ces_pkg::ADDR_EDGE_TYPE_PARAM, ces_pkg::ADDR_EDGE_STYLE_SELECT,
		ces_pkg::ADDR_EDGE_LENGTH_CONFIG, ces_pkg::ADDR_SHAPER_CTRL, ces_pkg::ADDR_SHAPER_STATUS};
	assign start = acc && pwrite && paddr == ces_pkg::ADDR_SHAPER_CTRL && !env_busy
		&& pwdata[1:0] != 2'b00;
	// Direction of the running edge and its length, so the landing level can be judged
	always_comb begin
		nxt_fall = start ? pwdata[0] : fall_ff;
		nxt_cnt = env_busy ? cnt_ff + 16'h0001 : 16'h0000;
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			fall_ff <= 1'b0;
			cnt_ff <= 16'h0000;
		end else begin
			fall_ff <= nxt_fall;
			cnt_ff <= nxt_cnt;
		end
	end
	a_ready_high: assert property (pready) else $error("pready low");
	a_err_unmapped: assert property (acc && !mapped |-> pslverr) else $error("no error");
	a_err_mapped: assert property (acc && mapped |-> !pslverr) else $error("stray error");
	a_upper_zero: assert property (acc && !pwrite |-> prdata[31:16] == 16'h0000)
		else $error("upper bits set");
	a_start_busy: assert property (start |=> env_busy || env_done) else $error("no start");
	a_done_pulse: assert property (env_done |=> !env_done) else $error("done too long");
	a_done_idle: assert property (env_done |-> !env_busy) else $error("busy at done");
	a_land_level: assert property (env_done |-> env_amp == (fall_ff ? 8'h00 : 8'hFF))
		else $error("wrong final level");
	a_idle_hold: assert property (!env_busy && !start |=> $stable(env_amp))
		else $error("amp moved idle");
	a_busy_bound: assert property (cnt_ff <= 62 * CARRIER_DIV) else $error("edge too long");
endmodule : ces_shaper_monitor

bind ces_shaper ces_shaper_monitor #(.CARRIER_DIV(CARRIER_DIV)) i_mon (.clk(clk), .rst_n(rst_n),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .pa_supply_gain(pa_supply_gain),
	.env_amp(env_amp), .env_busy(env_busy), .env_done(env_done));

// ### tb_ces_shaper.sv
module tb_ces_shaper;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [7:0]  pa_supply_gain = 8'hFF;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [7:0]  env_amp;
	logic        env_busy;
	logic        env_done;
	logic [31:0] seed = 32'h0001_1E0F;
	logic [31:0] rd;
	logic        er;
	logic [7:0]  ty;
	logic [7:0]  st;
	logic [7:0]  ln;
	int          mismatches = 0;
	int          checks_done = 0;
	int          cyc = 0;
	ces_shaper #(.CARRIER_DIV(1)) i_ces_shaper (.clk(clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pa_supply_gain(pa_supply_gain),
		.env_amp(env_amp), .env_busy(env_busy), .env_done(env_done));
	// Clock, and a cycle ceiling in case a wait never ends
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			end_sim();
		end
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// Busy cycles an edge should take: one per state, two when doubled, one if empty
	function automatic int exp_busy(logic [7:0] len);
		if (len[4:0] == 5'h00)
			return 1;
		return len[4:0] * (len[7] ? 2 : 1);
	endfunction : exp_busy
	task automatic end_sim();
		$display("checks_done %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_sim
	// One APB transfer; an idle edge first so psel never moves twice in a time step
	task automatic apb(logic w, logic [15:0] a, logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Start an edge and count busy cycles until done; one tick per clock here.
	// Busy is already up in the cycle after the access edge, so look before waiting.
	task automatic run(logic fall, logic [7:0] len);
		int n;
		n = 0;
		apb(1'b1, ces_pkg::ADDR_SHAPER_CTRL, fall ? 32'h0000_0001 : 32'h0000_0002);
		repeat (100) begin
			#1;
			if (env_done === 1'b1)
				break;
			if (env_busy === 1'b1)
				n++;
			@(posedge clk);
		end
		chk("done", 32'h0000_0001, {31'h0, env_done});
		chk("states", exp_busy(len), n);
		chk("amp", fall ? 32'h0000_0000 : 32'h0000_00FF, {24'h0, env_amp});
		apb(1'b0, ces_pkg::ADDR_SHAPER_STATUS, 32'h0);
		chk("status", {16'h0000, len[4:0], 2'b00, fall, fall ? 8'h00 : 8'hFF}, rd);
	endtask : run
	// Main sequence: reset values, refusal, then edges over every type code
	initial begin
		static logic [7:0] tys [9] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h00, 8'h07,
			8'h0F};
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		apb(1'b0, ces_pkg::ADDR_EDGE_TYPE_PARAM, 32'h0);
		chk("type rst", {24'h0, ces_pkg::RST_EDGE_TYPE}, rd);
		apb(1'b0, ces_pkg::ADDR_EDGE_LENGTH_CONFIG, 32'h0);
		chk("len rst", {24'h0, ces_pkg::RST_EDGE_LENGTH}, rd);
		apb(1'b1, 16'h0004, 32'hFFFF_FFFF);
		chk("wr err", 32'h0000_0001, {31'h0, er});
		apb(1'b0, 16'h0004, 32'h0);
		chk("rd err", 32'h0000_0001, {31'h0, er});
		chk("rd zero", 32'h0000_0000, rd);
		for (int i = 0; i < 14; i++) begin
			ty = tys[i % 9];
			st = 8'(rnd());
			ln = (i == 0) ? 8'h00 : (i == 1) ? 8'h01 : (i == 2) ? 8'h9F : 8'(rnd());
			apb(1'b1, ces_pkg::ADDR_EDGE_TYPE_PARAM, {24'h0, ty[3:0], ty[3:0]});
			// Changed on a rising edge, right after a transfer has ended there
			pa_supply_gain <= 8'(rnd());
			apb(1'b1, ces_pkg::ADDR_EDGE_STYLE_SELECT, {rnd() & 32'hFFFF_FF00} | st);
			apb(1'b0, ces_pkg::ADDR_EDGE_STYLE_SELECT, 32'h0);
			chk("style", {24'h0, st}, rd);
			apb(1'b1, ces_pkg::ADDR_EDGE_LENGTH_CONFIG, {24'h0, ln});
			apb(1'b0, ces_pkg::ADDR_EDGE_LENGTH_CONFIG, 32'h0);
			chk("length", {24'h0, ln}, rd);
			run(i % 2 == 0, ln);
		end
		// Reset in the middle of a long edge drops the run and restores defaults
		apb(1'b1, ces_pkg::ADDR_EDGE_LENGTH_CONFIG, 32'h0000_009F);
		apb(1'b1, ces_pkg::ADDR_SHAPER_CTRL, 32'h0000_0001);
		repeat (5) @(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		chk("rst busy", 32'h0000_0000, {31'h0, env_busy});
		chk("rst amp", {24'h0, ces_pkg::AMP_HIGH}, {24'h0, env_amp});
		apb(1'b0, ces_pkg::ADDR_EDGE_LENGTH_CONFIG, 32'h0);
		chk("rst len", {24'h0, ces_pkg::RST_EDGE_LENGTH}, rd);
		end_sim();
	end
endmodule : tb_ces_shaper
